// ===== hdl/status_irq_consts.svh
`ifndef STATUS_IRQ_CONSTS_SVH
`define STATUS_IRQ_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define OFS_IND_SYS 16'h000C
`define OFS_IND_INPUT 16'h000D
`define OFS_IND_PLL 16'h000E
`define OFS_IND_TUNE 16'h000F
`define OFS_FLG_SYS 16'h0011
`define OFS_FLG_INPUT 16'h0012
`define OFS_FLG_PLL 16'h0013
`define OFS_FLG_TUNE 16'h0014
`define OFS_MSK_SYS 16'h0017
`define OFS_MSK_INPUT 16'h0018
`define OFS_MSK_PLL 16'h0019
`define OFS_MSK_TUNE 16'h001A

// ****************************************
// field positions inside each byte
// ****************************************
`define BIT_DEVICE_TUNING 0
`define BIT_XTAL_MISSING 1
`define BIT_REF_MISSING 2
`define BIT_XTAL_LOCK_ERR 3
`define BIT_SMBUS_TIMEOUT 5
`define BIT_PLL_UNLOCK 1
`define BIT_FREERUN 5
`define BIT_PLL_TUNING 5
`define LSB_INPUT_MISSING 0
`define LSB_INPUT_OFFSET 4

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_MASK 16'h0000
`define RST_FLAG 16'h0000

`endif

// ===== hdl/status_irq_pkg.sv
package status_irq_pkg;

   // one bit per status source; indicators, flags and masks share it
   typedef struct packed {
      logic [3:0] input_freq_offset;
      logic [3:0] input_missing;
      logic pll_unlock;
      logic freerun_state;
      logic pll_tuning;
      logic device_tuning;
      logic xtal_missing;
      logic ref_missing;
      logic xtal_lock_error;
      logic smbus_timeout;
   } status_s;

   // register group selected by an address, one-hot
   typedef enum logic [4:0] {
      grp_none = 5'b0_0001,
      grp_sys = 5'b0_0010,
      grp_input = 5'b0_0100,
      grp_pll = 5'b0_1000,
      grp_tune = 5'b1_0000
   } group_e;

   typedef logic [7:0] byte_t;

endpackage : status_irq_pkg

// ===== hdl/status_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "status_irq_consts.svh"


module status_irq_ctrl
   import status_irq_pkg::*;
#(
   parameter int NUM_INPUTS = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire status_s indicators,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic interrupt_request_pin_n
);

   // ****************************************
   // parameter check
   // ****************************************
   // the byte layout has room for exactly four inputs
   generate
      if (NUM_INPUTS != 4) begin : g_bad_inputs
         $error("status_irq_ctrl supports only four inputs");
      end
   endgenerate

   // ****************************************
   // decode helpers
   // ****************************************
   // map an address onto one of four register groups of a kind
   function automatic group_e decode_group(
      input logic [15:0] addr,
      input logic [15:0] base_sys,
      input logic [15:0] base_in,
      input logic [15:0] base_pll,
      input logic [15:0] base_tune
   );
      group_e g;
      if (addr == base_sys) begin
         g = grp_sys;
      end else if (addr == base_in) begin
         g = grp_input;
      end else if (addr == base_pll) begin
         g = grp_pll;
      end else if (addr == base_tune) begin
         g = grp_tune;
      end else begin
         g = grp_none;
      end
      return g;
   endfunction : decode_group

   // place written byte bits onto the sources that the group holds
   function automatic status_s write_view(input group_e g, input byte_t d);
      status_s v;
      v = status_s'(`RST_FLAG);
      case (g)
         grp_sys: begin
            v.device_tuning = d[`BIT_DEVICE_TUNING];
            v.xtal_missing = d[`BIT_XTAL_MISSING];
            v.ref_missing = d[`BIT_REF_MISSING];
            v.xtal_lock_error = d[`BIT_XTAL_LOCK_ERR];
            v.smbus_timeout = d[`BIT_SMBUS_TIMEOUT];
         end
         grp_input: begin
            v.input_missing = d[`LSB_INPUT_MISSING +: 4];
            v.input_freq_offset = d[`LSB_INPUT_OFFSET +: 4];
         end
         grp_pll: begin
            v.pll_unlock = d[`BIT_PLL_UNLOCK];
            v.freerun_state = d[`BIT_FREERUN];
         end
         grp_tune: begin
            v.pll_tuning = d[`BIT_PLL_TUNING];
         end
         default: begin
            v = status_s'(`RST_FLAG);
         end
      endcase
      return v;
   endfunction : write_view

   // gather the sources of a group into its byte; spare bits read zero
   function automatic byte_t byte_view(input group_e g, input status_s v);
      byte_t b;
      b = `RST_BYTE;
      case (g)
         grp_sys: begin
            b[`BIT_DEVICE_TUNING] = v.device_tuning;
            b[`BIT_XTAL_MISSING] = v.xtal_missing;
            b[`BIT_REF_MISSING] = v.ref_missing;
            b[`BIT_XTAL_LOCK_ERR] = v.xtal_lock_error;
            b[`BIT_SMBUS_TIMEOUT] = v.smbus_timeout;
         end
         grp_input: begin
            b[`LSB_INPUT_MISSING +: 4] = v.input_missing;
            b[`LSB_INPUT_OFFSET +: 4] = v.input_freq_offset;
         end
         grp_pll: begin
            b[`BIT_PLL_UNLOCK] = v.pll_unlock;
            b[`BIT_FREERUN] = v.freerun_state;
         end
         grp_tune: begin
            b[`BIT_PLL_TUNING] = v.pll_tuning;
         end
         default: begin
            b = `RST_BYTE;
         end
      endcase
      return b;
   endfunction : byte_view

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta;
   logic rst_n_sync;

   // assert at once, release two edges later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   // ****************************************
   // address decode
   // ****************************************
   group_e ind_grp;
   group_e flg_grp;
   group_e msk_grp;
   status_s flag_field;
   status_s flag_zeros;
   status_s flag_clear;
   status_s mask_field;
   status_s mask_data;

   // each register kind has its own four addresses
   assign ind_grp = decode_group(reg_addr, `OFS_IND_SYS, `OFS_IND_INPUT, `OFS_IND_PLL,
                                 `OFS_IND_TUNE);
   assign flg_grp = decode_group(reg_addr, `OFS_FLG_SYS, `OFS_FLG_INPUT, `OFS_FLG_PLL,
                                 `OFS_FLG_TUNE);
   assign msk_grp = decode_group(reg_addr, `OFS_MSK_SYS, `OFS_MSK_INPUT, `OFS_MSK_PLL,
                                 `OFS_MSK_TUNE);

   // a zero written into a flag bit asks to clear it; a one is ignored
   assign flag_field = write_view(flg_grp, 8'hFF);
   assign flag_zeros = write_view(flg_grp, ~reg_wdata);
   assign flag_clear = reg_write ? status_s'(flag_field & flag_zeros) : status_s'(`RST_FLAG);

   // only the bits a mask register holds are touched by its write
   assign mask_field = reg_write ? write_view(msk_grp, 8'hFF) : status_s'(`RST_MASK);
   assign mask_data = write_view(msk_grp, reg_wdata);

   // ****************************************
   // interrupt masks
   // ****************************************
   status_s irq_mask;

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         irq_mask <= status_s'(`RST_MASK);
      end else begin
         irq_mask <= status_s'((irq_mask & ~mask_field) | (mask_data & mask_field));
      end
   end

   // ****************************************
   // sticky flags
   // ****************************************
   logic [$bits(status_s)-1:0] ind_vec;
   logic [$bits(status_s)-1:0] clr_vec;
   logic [$bits(status_s)-1:0] flag_vec;
   status_s sticky_flag;

   assign ind_vec = indicators;
   assign clr_vec = flag_clear;
   assign sticky_flag = status_s'(flag_vec);

   // one sticky cell per source; a live indicator beats a clear
   generate
      for (genvar i = 0; i < $bits(status_s); i++) begin : g_sticky
         always_ff @(posedge clk or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
               flag_vec[i] <= 1'b0;
            end else if (ind_vec[i]) begin
               flag_vec[i] <= 1'b1;
            end else if (clr_vec[i]) begin
               flag_vec[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************
   // interrupt pin
   // ****************************************
   logic any_unmasked;

   assign any_unmasked = |(sticky_flag & ~irq_mask);

   // registered level, low while an unmasked flag stands
   // pin level
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         interrupt_request_pin_n <= 1'b1;
      end else begin
         interrupt_request_pin_n <= ~any_unmasked;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   byte_t next_rdata;

   // unmapped addresses read zero; data holds until the next read
   always_comb begin
      next_rdata = `RST_BYTE;
      if (ind_grp != grp_none) begin
         next_rdata = byte_view(ind_grp, indicators);
      end else if (flg_grp != grp_none) begin
         next_rdata = byte_view(flg_grp, sticky_flag);
      end else if (msk_grp != grp_none) begin
         next_rdata = byte_view(msk_grp, irq_mask);
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         reg_rdata <= `RST_BYTE;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : status_irq_ctrl

`default_nettype wire

// ===== bench/status_irq_props.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// port checker
// ****
module status_irq_props
   import status_irq_pkg::*;
#(
   parameter int NUM_INPUTS = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire status_s indicators,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic interrupt_request_pin_n
);
   logic [15:0] flg;
   logic [15:0] msk;
   logic [15:0] clr;
   // byte lane to status bit order
   function automatic logic [15:0] spread(input logic [1:0] g, input logic [7:0] b);
      case (g)
         2'd0: spread = {11'b0, b[0], b[1], b[2], b[3], b[5]};
         2'd1: spread = {b[7:4], b[3:0], 8'b0};
         2'd2: spread = {8'b0, b[1], b[5], 6'b0};
         default: spread = {10'b0, b[5], 5'b0};
      endcase
   endfunction : spread
   // zero bits of a flag write clear, set wins
   assign clr = (reg_write && reg_addr >= 16'h0011 && reg_addr <= 16'h0014) ?
      spread(reg_addr[1:0] - 2'd1, ~reg_wdata) : 16'h0000;
   // shadow masks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         msk <= '0;
      end else if (reg_write && reg_addr >= 16'h0017 && reg_addr <= 16'h001A) begin
         msk <= (msk & ~spread(reg_addr[1:0] + 2'd1, 8'hFF)) |
            spread(reg_addr[1:0] + 2'd1, reg_wdata);
      end
   end
   // shadow sticky flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flg <= '0;
      end else begin
         flg <= (flg & ~clr) | indicators;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_pin_level: assert property (interrupt_request_pin_n == !$past(|(flg & ~msk)))
      else $error("pin level wrong");
   a_pin_rise: assert property ((|(indicators & ~msk)) && !reg_write |-> ##2
      !interrupt_request_pin_n) else $error("pin not raised");
   a_pin_hold: assert property (!reg_write ##1 (!reg_write && !interrupt_request_pin_n)
      |=> !interrupt_request_pin_n) else $error("pin released alone");
   a_tune_flag: assert property (reg_read && reg_addr == 16'h0014 |=>
      reg_rdata == {2'b0, $past(flg[5]), 5'b0}) else $error("tune flag read");
   a_sys_flag: assert property (reg_read && reg_addr == 16'h0011 |=> reg_rdata ==
      $past({2'b0, flg[0], 1'b0, flg[1], flg[2], flg[3], flg[4]})) else $error("sys flag read");
   a_input_mask: assert property (reg_read && reg_addr == 16'h0018 |=>
      reg_rdata == $past(msk[15:8])) else $error("input mask read");
   a_tune_ind: assert property (reg_read && reg_addr == 16'h000F |=>
      reg_rdata == {2'b0, $past(indicators.pll_tuning), 5'b0}) else $error("tune ind read");
   a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("rdata moved");
   c_pin_low: cover property ($fell(interrupt_request_pin_n));
   c_pin_high: cover property ($rose(interrupt_request_pin_n));
   c_flag_seen: cover property (reg_read && reg_addr == 16'h0014 ##1 reg_rdata[5]);
endmodule : status_irq_props
bind status_irq_ctrl status_irq_props #(.NUM_INPUTS(NUM_INPUTS)) u_props (
   .clk(clk), .rstn(rstn), .indicators(indicators), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .interrupt_request_pin_n(interrupt_request_pin_n)
);
`default_nettype wire

// ===== bench/test_status_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// scenarios
// ****
module test_status_irq_ctrl
   import status_irq_pkg::*;
();
   logic clk = 1'b0;
   logic rstn = 1'b0;
   status_s ind = '0;
   logic [15:0] addr = '0;
   byte_t wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   byte_t rdata;
   logic pin_n;
   int fails = 0;
   int n_checks = 0;
   // full-mask image per group: sys, input, pll, tune
   byte_t grp [4] = '{8'h2F, 8'hFF, 8'h22, 8'h20};
   always #50 clk = ~clk;
   status_irq_ctrl #(.NUM_INPUTS(4)) dut (
      .clk(clk), .rstn(rstn), .indicators(ind), .reg_addr(addr), .reg_wdata(wdata),
      .reg_write(wr_en), .reg_read(rd_en), .reg_rdata(rdata), .interrupt_request_pin_n(pin_n)
   );
   task automatic chk(string nm, byte_t seen, byte_t exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(logic [15:0] a, byte_t d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
      // idle edge so a following call never re-raises the strobe in this step
      cyc(1);
   endtask : wr
   task automatic rd(logic [15:0] a, byte_t e);
      addr = a;
      rd_en = 1'b1;
      cyc(1);
      rd_en = 1'b0;
      chk("rdata", rdata, e);
      cyc(1);
   endtask : rd
   task automatic chk_pin(logic e);
      chk("pin", {7'b0, pin_n}, {7'b0, e});
   endtask : chk_pin
   // two-flop release needs spare edges
   task automatic do_reset();
      rstn = 1'b0;
      cyc(10);
      rstn = 1'b1;
      cyc(3);
   endtask : do_reset
   task automatic t_defaults();
      for (int i = 0; i < 4; i++) begin
         rd(16'h0011 + 16'(i), 8'h00);
         rd(16'h0017 + 16'(i), 8'h00);
      end
      rd(16'h0010, 8'h00);
      chk_pin(1'b1);
   endtask : t_defaults
   task automatic t_each();
      for (int i = 0; i < 16; i++) begin
         ind = status_s'(16'h0001 << i);
         cyc(1);
         ind = '0;
         cyc(1);
         chk_pin(1'b0);
         for (int g = 0; g < 4; g++) wr(16'h0011 + 16'(g), 8'h00);
         cyc(1);
         chk_pin(1'b1);
      end
   endtask : t_each
   task automatic t_sticky();
      ind.pll_tuning = 1'b1;
      cyc(1);
      rd(16'h000F, 8'h20);
      wr(16'h0014, 8'h00);
      rd(16'h0014, 8'h20);
      chk_pin(1'b0);
      ind.pll_tuning = 1'b0;
      rd(16'h000F, 8'h00);
      rd(16'h0014, 8'h20);
      wr(16'h0014, 8'h00);
      rd(16'h0014, 8'h00);
      chk_pin(1'b1);
   endtask : t_sticky
   task automatic t_mask();
      for (int g = 0; g < 4; g++) begin
         wr(16'h0017 + 16'(g), 8'hFF);
         rd(16'h0017 + 16'(g), grp[g]);
      end
      ind = status_s'(16'hFFFF);
      cyc(1);
      ind = '0;
      cyc(2);
      chk_pin(1'b1);
      for (int g = 0; g < 4; g++) rd(16'h0011 + 16'(g), grp[g]);
      wr(16'h001A, 8'h00);
      cyc(1);
      chk_pin(1'b0);
      do_reset();
      t_defaults();
   endtask : t_mask
   // one source under full masks: quiet, then unmasking its bit alone drops the pin
   task automatic mask_one(logic [15:0] a, byte_t m, logic [15:0] s);
      ind = status_s'(s);
      cyc(1);
      ind = '0;
      cyc(2);
      chk_pin(1'b1);
      wr(a, ~m);
      chk_pin(1'b0);
      wr(a, 8'hFF);
      wr(a - 16'h0006, 8'h00);
      chk_pin(1'b1);
   endtask : mask_one
   task automatic t_mask_each();
      for (int g = 0; g < 4; g++) wr(16'h0017 + 16'(g), 8'hFF);
      mask_one(16'h0018, 8'h01, 16'h0100);
      mask_one(16'h0018, 8'h10, 16'h1000);
      mask_one(16'h0019, 8'h02, 16'h0080);
      mask_one(16'h0019, 8'h20, 16'h0040);
      mask_one(16'h001A, 8'h20, 16'h0020);
      mask_one(16'h0017, 8'h01, 16'h0010);
      mask_one(16'h0017, 8'h02, 16'h0008);
      mask_one(16'h0017, 8'h04, 16'h0004);
      mask_one(16'h0017, 8'h08, 16'h0002);
      mask_one(16'h0017, 8'h20, 16'h0001);
   endtask : t_mask_each
   task automatic end_sim();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      do_reset();
      t_defaults();
      t_each();
      t_sticky();
      t_mask();
      t_mask_each();
      end_sim();
   end
   // watchdog, runs need well under 3000 cycles
   initial begin
      #300_000;
      fails++;
      end_sim();
   end
endmodule : test_status_irq_ctrl
`default_nettype wire
